// [hdl/irq_ctrl_cfg.svh]
// Register offsets, reset values and timing counts of the interrupt block
`ifndef IRQ_CTRL_CFG_SVH
`define IRQ_CTRL_CFG_SVH
`define OFS_ENABLE 8'h00
`define OFS_MAP_A 8'h04
`define OFS_MAP_B 8'h08
`define OFS_SOURCE 8'h0C
`define OFS_PIN_CFG 8'h10
`define OFS_MODE 8'h14
`define OFS_STATUS 8'h18
`define OFS_CLEAR 8'h1C
`define OFS_IRQ_STAT 8'h20
`define OFS_IRQ_MASK 8'h24
`define MODE_RST 4'h0
`define PIN_CFG_RST 4'h5
`define CLK_HZ 200000000
`define TICK_US 1
`define TICK_CYC ((`CLK_HZ / 1000000) * `TICK_US)
`define NODATA_GAP_US 50
`define FIXED_HOLD_US 12500
// Temporary hold times in microsecond ticks
`define HOLD_250MS 250000
`define HOLD_500MS 500000
`define HOLD_1S 1000000
`define HOLD_2S 2000000
`define HOLD_4S 4000000
`define HOLD_8S 8000000
`define HOLD_250US 250
`define HOLD_500US 500
`define HOLD_1MS 1000
`define HOLD_12MS5 12500
`define HOLD_25MS 25000
`define HOLD_50MS 50000
`endif

// [hdl/irq_ctrl_pkg.sv]
// Types shared by the interrupt controller files
package irq_ctrl_pkg;
  typedef enum logic [1:0] {MODE_NONLATCH, MODE_LATCH, MODE_TEMP} clr_mode_t;
  typedef struct packed {
    logic drv_a;
    logic pol_a;
    logic drv_b;
    logic pol_b;
  } pin_cfg_t;
  typedef struct packed {
    logic [7:0] cond;
    logic [7:0] cond_raw;
  } engine_in_t;
endpackage

// [hdl/irq_pin_drive.sv]
// One interrupt pin: polarity and push-pull or open-drain drive
`timescale 1ns/1ps
module irq_pin_drive
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic active,
  input wire logic polarity,
  input wire logic driver_type,
  // Pin
  output logic pin_o,
  output logic pin_oe
);
  logic lvl_d;
  logic lvl_q;
  logic oe_d;
  logic oe_q;

  // Pin level and enable
  always_comb
  begin
    lvl_d = active ? polarity : ~polarity;
    oe_d = driver_type ? (lvl_d == ~polarity ? 1'b0 : 1'b1) : 1'b1;
    if (driver_type)
    begin
      oe_d = active;
    end
  end

  // Registered pin outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lvl_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else
    begin
      lvl_q <= lvl_d;
      oe_q <= oe_d;
    end
  end

  assign pin_o = lvl_q;
  assign pin_oe = oe_q;
endmodule

// [hdl/accel_interrupt_controller.sv]
// Accelerometer interrupt controller with AXI4-Lite registers
//
// Behaviour
// - Eight engines, enabled, set status and pin
// - Each pin ORs its mapped interrupts
// - Status sets only on data update
// - Disabling clears that status at once
// - Four-bit code picks common clearing mode
// - Temporary mode clears after coded hold; orientation and flat use fixed hold
// - Timed and non-latched clears wait for condition to end
// - Non-latched follows condition; some self-clear
// - Latched holds until clear bit written; orientation and flat clear after fixed hold
// - Still-true latched reasserts next update
// - Source bits pick filtered or unfiltered; orientation and flat always filtered
// - Per-interrupt map bit for each pin
// - Pin polarity bit sets active level
// - Driver bit picks open-drain or push-pull
// - New-data always non-latched, self-clears
`timescale 1ns/1ps
`include "irq_ctrl_cfg.svh"
module accel_interrupt_controller
#(
  parameter int NUM_ENG = 8,
  parameter int NEWDATA_IDX = 0,
  parameter int ORIENT_IDX = 6,
  parameter int FLAT_IDX = 7
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Engine conditions and data update strobe
  input wire irq_ctrl_pkg::engine_in_t eng_in,
  input wire logic data_update,
  // Source selection to engines
  output logic [NUM_ENG-1:0] use_unfiltered,
  // Interrupt pins
  output logic irq_pin_a_o,
  output logic irq_pin_a_oe,
  output logic irq_pin_b_o,
  output logic irq_pin_b_oe,
  // Interrupt to system
  output logic irq
);
  localparam logic [31:0] TICK_CYC = 32'(`TICK_CYC);
  localparam logic [31:0] FIXED_HOLD = 32'(`FIXED_HOLD_US);

  // Elaboration check
  if (NUM_ENG != 8 || FLAT_IDX >= NUM_ENG || ORIENT_IDX >= NUM_ENG)
  begin : g_bad
    $error("Engine count or index out of range");
  end

  function automatic irq_ctrl_pkg::clr_mode_t decode_mode(logic [3:0] c);
    irq_ctrl_pkg::clr_mode_t m;
    m = irq_ctrl_pkg::MODE_TEMP;
    if (c[2:0] == 3'h0)
    begin
      m = irq_ctrl_pkg::MODE_NONLATCH;
    end
    else if (c[2:0] == 3'h7)
    begin
      m = irq_ctrl_pkg::MODE_LATCH;
    end
    return m;
  endfunction

  // Hold time in ticks for a temporary code
  function automatic logic [31:0] hold_ticks(logic [3:0] c);
    logic [31:0] t;
    t = 32'h0000_0001;
    case (c)
      4'h1: t = 32'(`HOLD_250MS);
      4'h2: t = 32'(`HOLD_500MS);
      4'h3: t = 32'(`HOLD_1S);
      4'h4: t = 32'(`HOLD_2S);
      4'h5: t = 32'(`HOLD_4S);
      4'h6: t = 32'(`HOLD_8S);
      4'h9: t = 32'(`HOLD_250US);
      4'hA: t = 32'(`HOLD_500US);
      4'hB: t = 32'(`HOLD_1MS);
      4'hC: t = 32'(`HOLD_12MS5);
      4'hD: t = 32'(`HOLD_25MS);
      4'hE: t = 32'(`HOLD_50MS);
      default: t = 32'h0000_0001;
    endcase
    return t;
  endfunction

  // ************************************************
  // Register bus
  // ************************************************
  logic aw_ok_q, aw_ok_d, w_ok_q, w_ok_d, bvalid_q, bvalid_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [7:0] en_q, en_d, map_a_q, map_a_d, map_b_q, map_b_d;
  logic [7:0] src_q, src_d;
  irq_ctrl_pkg::pin_cfg_t pcfg_q, pcfg_d;
  logic [3:0] mode_q, mode_d;
  logic [1:0] ev_q, ev_d, ev_mask_q, ev_mask_d;
  logic [7:0] status_q, status_d;
  logic do_write, latch_clear;
  logic [1:0] ev_set;

  assign s_axi_awready = !aw_ok_q && !bvalid_q;
  assign s_axi_wready = !w_ok_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign do_write = aw_ok_q && w_ok_q && !bvalid_q;
  assign latch_clear = do_write && awaddr_q == `OFS_CLEAR && wdata_q[0];

  // Bus handshake and register writes
  always_comb
  begin
    aw_ok_d = aw_ok_q;
    w_ok_d = w_ok_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    bvalid_d = bvalid_q && !s_axi_bready;
    bresp_d = bresp_q;
    en_d = en_q;
    map_a_d = map_a_q;
    map_b_d = map_b_q;
    src_d = src_q;
    pcfg_d = pcfg_q;
    mode_d = mode_q;
    ev_mask_d = ev_mask_q;
    ev_d = ev_q | ev_set;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_ok_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_ok_d = 1'b1;
      wdata_d = s_axi_wdata;
    end
    if (do_write)
    begin
      aw_ok_d = 1'b0;
      w_ok_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = 2'b00;
      case (awaddr_q)
        `OFS_ENABLE: en_d = wdata_q[7:0];
        `OFS_MAP_A: map_a_d = wdata_q[7:0];
        `OFS_MAP_B: map_b_d = wdata_q[7:0];
        `OFS_SOURCE: src_d = wdata_q[7:0];
        `OFS_PIN_CFG: pcfg_d = wdata_q[3:0];
        `OFS_MODE: mode_d = wdata_q[3:0];
        `OFS_CLEAR: ;
        `OFS_STATUS: ;
        // Set wins over write-one clear
        `OFS_IRQ_STAT: ev_d = (ev_q & ~wdata_q[1:0]) | ev_set;
        `OFS_IRQ_MASK: ev_mask_d = wdata_q[1:0];
        default: bresp_d = 2'b10;
      endcase
    end
  end

  // Read channel
  always_comb
  begin
    rvalid_d = rvalid_q && !s_axi_rready;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_d = 1'b1;
      rresp_d = 2'b00;
      rdata_d = 32'h0000_0000;
      case (s_axi_araddr)
        `OFS_ENABLE: rdata_d[7:0] = en_q;
        `OFS_MAP_A: rdata_d[7:0] = map_a_q;
        `OFS_MAP_B: rdata_d[7:0] = map_b_q;
        `OFS_SOURCE: rdata_d[7:0] = src_q;
        `OFS_PIN_CFG: rdata_d[3:0] = pcfg_q;
        `OFS_MODE: rdata_d[3:0] = mode_q;
        `OFS_STATUS: rdata_d[7:0] = status_q;
        `OFS_CLEAR: ;
        `OFS_IRQ_STAT: rdata_d[1:0] = ev_q;
        `OFS_IRQ_MASK: rdata_d[1:0] = ev_mask_q;
        default: rresp_d = 2'b10;
      endcase
    end
  end

  // Bus and configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_ok_q <= 1'b0;
      w_ok_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      bvalid_q <= 1'b0;
      bresp_q <= 2'b00;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'b00;
      en_q <= 8'h00;
      map_a_q <= 8'h00;
      map_b_q <= 8'h00;
      src_q <= 8'h00;
      pcfg_q <= `PIN_CFG_RST;
      mode_q <= `MODE_RST;
      ev_q <= 2'b00;
      ev_mask_q <= 2'b00;
    end
    else
    begin
      aw_ok_q <= aw_ok_d;
      w_ok_q <= w_ok_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      en_q <= en_d;
      map_a_q <= map_a_d;
      map_b_q <= map_b_d;
      src_q <= src_d;
      pcfg_q <= pcfg_d;
      mode_q <= mode_d;
      ev_q <= ev_d;
      ev_mask_q <= ev_mask_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign irq = |(ev_q & ev_mask_q);

  always_comb
  begin
    use_unfiltered = src_q;
    use_unfiltered[ORIENT_IDX] = 1'b0;
    use_unfiltered[FLAT_IDX] = 1'b0;
  end

  // ************************************************
  // Status engines
  // ************************************************
  logic [31:0] tick_cnt_q, tick_cnt_d;
  logic tick;
  logic [31:0] hold_q [NUM_ENG];
  logic [31:0] hold_d [NUM_ENG];
  logic [7:0] cond;
  irq_ctrl_pkg::clr_mode_t mode;

  assign mode = decode_mode(mode_q);
  assign tick = tick_cnt_q == TICK_CYC - 32'h0000_0001;
  always_comb
  begin
    for (int i = 0; i < NUM_ENG; i++)
    begin
      cond[i] = use_unfiltered[i] ? eng_in.cond_raw[i] : eng_in.cond[i];
    end
  end

  always_comb
  begin
    tick_cnt_d = tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
  end

  // Per-engine status update
  always_comb
  begin
    status_d = status_q;
    for (int i = 0; i < NUM_ENG; i++)
    begin
      hold_d[i] = hold_q[i];
      if (status_q[i] && tick && hold_q[i] != 32'h0000_0000)
      begin
        hold_d[i] = hold_q[i] - 32'h0000_0001;
      end
      if (data_update)
      begin
        if (en_q[i] && cond[i] && !status_q[i])
        begin
          status_d[i] = 1'b1;
          if (i == NEWDATA_IDX || i == ORIENT_IDX || i == FLAT_IDX)
          begin
            hold_d[i] = FIXED_HOLD;
          end
          else
          begin
            hold_d[i] = hold_ticks(mode_q);
          end
        end
        else if (i == NEWDATA_IDX)
        begin
          status_d[i] = en_q[i] && cond[i];
        end
        else if (!cond[i] && mode == irq_ctrl_pkg::MODE_NONLATCH &&
                 i != ORIENT_IDX && i != FLAT_IDX)
        begin
          status_d[i] = 1'b0;
        end
      end
      if (status_q[i] && hold_q[i] == 32'h0000_0000 && !cond[i] &&
          (mode == irq_ctrl_pkg::MODE_TEMP || i == ORIENT_IDX ||
           i == FLAT_IDX) && i != NEWDATA_IDX)
      begin
        status_d[i] = 1'b0;
      end
      // latched cleared by software, sets again later
      if (latch_clear && mode == irq_ctrl_pkg::MODE_LATCH &&
          i != NEWDATA_IDX && !(data_update && cond[i]))
      begin
        status_d[i] = 1'b0;
      end
      if (!en_q[i])
      begin
        status_d[i] = 1'b0;
      end
    end
  end

  // Status and timer registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tick_cnt_q <= 32'h0000_0000;
      status_q <= 8'h00;
      for (int i = 0; i < NUM_ENG; i++)
      begin
        hold_q[i] <= 32'h0000_0000;
      end
    end
    else
    begin
      tick_cnt_q <= tick_cnt_d;
      status_q <= status_d;
      for (int i = 0; i < NUM_ENG; i++)
      begin
        hold_q[i] <= hold_d[i];
      end
    end
  end

  // ************************************************
  // Pins and events
  // ************************************************
  logic act_a, act_b, act_a_q, act_b_q;
  assign act_a = |(status_q & map_a_q);
  assign act_b = |(status_q & map_b_q);
  assign ev_set = {act_b & ~act_b_q, act_a & ~act_a_q};

  // Pin activity history for events
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      act_a_q <= 1'b0;
      act_b_q <= 1'b0;
    end
    else
    begin
      act_a_q <= act_a;
      act_b_q <= act_b;
    end
  end

  // Pin A driver
  irq_pin_drive u_pin_a
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .active(act_a),
    .polarity(pcfg_q.pol_a),
    .driver_type(pcfg_q.drv_a),
    .pin_o(irq_pin_a_o),
    .pin_oe(irq_pin_a_oe)
  );

  // Pin B driver
  irq_pin_drive u_pin_b
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .active(act_b),
    .polarity(pcfg_q.pol_b),
    .driver_type(pcfg_q.drv_b),
    .pin_o(irq_pin_b_o),
    .pin_oe(irq_pin_b_oe)
  );
endmodule

// [testbench/irq_host_model.sv]
// Host side of the two interrupt lines, with pull resistors
`timescale 1ns/1ps
module irq_host_model
(
  // Pins from the device
  input wire logic pin_a_o,
  input wire logic pin_a_oe,
  input wire logic pin_b_o,
  input wire logic pin_b_oe,
  // Pull resistor sides chosen from the pin polarity
  input wire logic pol_a,
  input wire logic pol_b,
  // Resolved line levels
  output logic line_a,
  output logic line_b
);
  assign line_a = pin_a_oe ? pin_a_o : ~pol_a;
  assign line_b = pin_b_oe ? pin_b_o : ~pol_b;
endmodule

// [testbench/irq_ctrl_chk.sv]
// Port checker for the interrupt controller
`timescale 1ns/1ps
module irq_ctrl_chk
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Outputs
  input wire logic [7:0] use_unfiltered,
  input wire logic irq_pin_a_oe,
  input wire logic irq_pin_b_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Bus answer timing and blocking
  a_wr_latency: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late");
  a_rd_latency: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  a_wr_block: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("write not blocked");
  a_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read not blocked");
  a_b_single: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid) else $error("response repeated");
  a_r_single: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid) else $error("read data repeated");
  a_fixed_src: assert property (use_unfiltered[7:6] == 2'b00)
    else $error("orientation or flat unfiltered");
  // Pins released during reset
  a_rst_pins: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> !irq_pin_a_oe && !irq_pin_b_oe)
    else $error("pin driven in reset");
  // Main scenarios
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_pins: cover property (irq_pin_a_oe && irq_pin_b_oe);
endmodule

// [testbench/testbench.sv]
// Self-checking bench of the interrupt controller
`timescale 1ns/1ps
`include "irq_ctrl_cfg.svh"
module testbench;
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr, use_unfiltered;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, data_update, irq;
  irq_ctrl_pkg::engine_in_t eng_in;
  logic irq_pin_a_o, irq_pin_a_oe, irq_pin_b_o, irq_pin_b_oe;
  logic pol_a, pol_b, line_a, line_b;
  int err_count, comparisons;

  // ****
  // Design, host and clock
  // ****
  accel_interrupt_controller i_dut
  (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .eng_in(eng_in),
    .data_update(data_update), .use_unfiltered(use_unfiltered),
    .irq_pin_a_o(irq_pin_a_o), .irq_pin_a_oe(irq_pin_a_oe),
    .irq_pin_b_o(irq_pin_b_o), .irq_pin_b_oe(irq_pin_b_oe),
    .irq(irq)
  );
  irq_host_model i_host (.pin_a_o(irq_pin_a_o), .pin_a_oe(irq_pin_a_oe),
    .pin_b_o(irq_pin_b_o), .pin_b_oe(irq_pin_b_oe), .pol_a(pol_a),
    .pol_b(pol_b), .line_a(line_a), .line_b(line_b));
  always #2.5 aclk = ~aclk;

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask

  // Bus write, both channels offered together; handshakes seen settled
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_hs, w_hs, b_hs;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(negedge aclk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_hs = s_axi_bvalid;
      if (b_hs)
      begin
        resp = s_axi_bresp;
      end
      @(posedge aclk);
      if (aw_hs)
      begin
        s_axi_awvalid <= 1'b0;
      end
      if (w_hs)
      begin
        s_axi_wvalid <= 1'b0;
      end
    end while (!b_hs);
  endtask

  // Bus read; data taken in the cycle rvalid stands
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic ar_hs, r_hs;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    v = 32'h0000_0000;
    do
    begin
      @(negedge aclk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs = s_axi_rvalid;
      if (r_hs)
      begin
        v = s_axi_rdata;
        resp = s_axi_rresp;
      end
      @(posedge aclk);
      if (ar_hs)
      begin
        s_axi_arvalid <= 1'b0;
      end
    end while (!r_hs);
  endtask

  // Read and compare
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(nm, e, v);
  endtask

  // New acceleration word, filtered and unfiltered conditions apart
  task automatic upd2(input logic [7:0] f, input logic [7:0] r);
    eng_in <= {f, r};
    data_update <= 1'b1;
    @(posedge aclk);
    data_update <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask

  // New acceleration word with given conditions
  task automatic upd(input logic [7:0] c);
    upd2(c, c);
  endtask

  // Verdict
  task automatic close_out();
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ****
  // Tests
  // ****
  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, data_update} = '0;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    eng_in = '0;
    {pol_a, pol_b} = 2'b11;
    err_count = 0;
    comparisons = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc("mode", `OFS_MODE, 32'h0000_0000);
    rc("pin cfg", `OFS_PIN_CFG, 32'h0000_0005);
    rd(8'h40, d);
    chk("unmapped resp", 32'h0000_0002, {30'h0, resp});
    wr(8'h40, 32'h0000_0000);
    chk("unmapped wr resp", 32'h0000_0002, {30'h0, resp});
    wr(`OFS_SOURCE, 32'h0000_00ff);
    wr(`OFS_MAP_A, 32'h0000_0002);
    chk("source", 32'h0000_003f, {24'h0, use_unfiltered});
    wr(`OFS_IRQ_MASK, 32'h0000_0001);
    // Every clearing code, new-data engine alongside
    for (int m = 0; m < 16; m++)
    begin
      wr(`OFS_MODE, m);
      wr(`OFS_ENABLE, 32'h0000_0003);
      upd(8'h03);
      chk("pin a set", 32'h1, {31'h0, line_a});
      rc("status set", `OFS_STATUS, 32'h0000_0003);
      upd(8'h00);
      d = (m[2:0] != 3'b000) ? 32'h2 : 32'h0;
      rc("status kept", `OFS_STATUS, d);
      wr(`OFS_CLEAR, 32'h0000_0001);
      d = (m[2:0] == 3'b111) ? 32'h0 : d;
      rc("status clear", `OFS_STATUS, d);
      wr(`OFS_ENABLE, 32'h0000_0000);
      rc("status off", `OFS_STATUS, 32'h0000_0000);
    end
    // Latched clear while condition holds
    wr(`OFS_MODE, 32'h0000_0007);
    wr(`OFS_ENABLE, 32'h0000_0002);
    upd(8'h02);
    wr(`OFS_CLEAR, 32'h0000_0001);
    rc("latch cleared", `OFS_STATUS, 32'h0000_0000);
    upd(8'h02);
    rc("latch again", `OFS_STATUS, 32'h0000_0002);
    // Event status, mask and clear
    chk("irq", 32'h1, {31'h0, irq});
    wr(`OFS_IRQ_MASK, 32'h0000_0000);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`OFS_IRQ_STAT, 32'h0000_0003);
    rc("event clear", `OFS_IRQ_STAT, 32'h0000_0000);
    // Pin A open-drain active low, pin B mapped
    wr(`OFS_MODE, 32'h0000_0000);
    wr(`OFS_PIN_CFG, 32'h0000_0009);
    pol_a <= 1'b0;
    wr(`OFS_MAP_B, 32'h0000_0002);
    upd(8'h00);
    chk("a released", 32'h0, {31'h0, irq_pin_a_oe});
    chk("a idle", 32'h1, {31'h0, line_a});
    upd(8'h02);
    chk("a active", 32'h0, {31'h0, line_a});
    chk("b active", 32'h1, {31'h0, line_b});
    rc("events", `OFS_IRQ_STAT, 32'h0000_0003);
    upd(8'h00);
    chk("a off", 32'h1, {31'h0, line_a});
    // Source selection and update-only refresh
    upd2(8'h00, 8'h02);
    rc("raw source", `OFS_STATUS, 32'h0000_0002);
    wr(`OFS_SOURCE, 32'h0000_0000);
    upd2(8'h00, 8'h02);
    rc("filtered source", `OFS_STATUS, 32'h0000_0000);
    eng_in <= 16'h0202;
    repeat (4) @(posedge aclk);
    rc("no update", `OFS_STATUS, 32'h0000_0000);
    // Temporary hold of 250 us
    wr(`OFS_MODE, 32'h0000_0009);
    upd(8'h02);
    repeat (40000) @(posedge aclk);
    upd(8'h00);
    repeat (5000) @(posedge aclk);
    rc("temp held", `OFS_STATUS, 32'h0000_0002);
    repeat (6000) @(posedge aclk);
    rc("temp gone", `OFS_STATUS, 32'h0000_0000);
    close_out();
  end

  // Watchdog
  initial
  begin
    repeat (100000) @(posedge aclk);
    err_count++;
    close_out();
  end
endmodule

bind accel_interrupt_controller irq_ctrl_chk i_chk
(
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .use_unfiltered(use_unfiltered),
  .irq_pin_a_oe(irq_pin_a_oe), .irq_pin_b_oe(irq_pin_b_oe)
);
